// *** scaler_task_pkg.sv ***
// Constants, register layout and state codes of the scaler task handler.
// Assumes a 12-bit AXI4-Lite byte address; register byte address is four times its index.
package scaler_task_pkg;
  localparam int          ADDR_W           = 12;
  localparam logic [9:0]  IDX_GLOBAL_CTRL  = 10'h080;
  localparam logic [9:0]  IDX_STATUS       = 10'h086;
  localparam logic [9:0]  IDX_GP_SELECT    = 10'h087;
  localparam logic [9:0]  IDX_SOFT_RESET   = 10'h088;
  localparam logic [9:0]  IDX_TASK_A       = 10'h090;
  localparam logic [9:0]  IDX_SOURCE_SEL   = 10'h091;
  localparam logic [9:0]  IDX_TRIGGER_SEL  = 10'h092;
  localparam logic [9:0]  IDX_TASK_B       = 10'h0c0;
  // Global control
  localparam int          BIT_TASK_A_EN    = 4;
  localparam int          BIT_TASK_B_EN    = 5;
  // Soft reset register
  localparam int          BIT_SOFT_RESET   = 5;
  localparam logic [7:0]  SOFT_RESET_INIT  = 8'h20;
  // Source select
  localparam int          BIT_SRC_XPORT    = 4;
  localparam int          BIT_RATE_60HZ    = 6;
  // Trigger select
  localparam int          BIT_FD_EDGE      = 7;
  localparam int          BIT_FD_POL       = 6;
  localparam int          BIT_VSEL_HI      = 5;
  localparam int          BIT_VEDGE        = 4;
  localparam int          BIT_HEDGE        = 2;
  // Task control fields
  localparam int          TASK_START_CONDITION_LSB         = 0;
  localparam int          BIT_REPEAT       = 2;
  localparam int          SKIP_LSB         = 3;
  localparam int          BIT_OFID_SRC     = 6;
  localparam int          BIT_MARKER       = 7;
  localparam logic [1:0]  TASK_START_CONDITION_NOW         = 2'h0;
  localparam logic [1:0]  TASK_START_CONDITION_VSYNC       = 2'h1;
  localparam logic [1:0]  TASK_START_CONDITION_FID0        = 2'h2;
  localparam logic [1:0]  TASK_START_CONDITION_FID1        = 2'h3;
  // Earliest start lines
  localparam logic [9:0]  LINE_DEC_F1_50   = 10'h004;
  localparam logic [9:0]  LINE_DEC_F1_60   = 10'h007;
  localparam logic [9:0]  LINE_DEC_F2_50   = 10'h003;
  localparam logic [9:0]  LINE_DEC_F2_60   = 10'h006;
  localparam logic [9:0]  LINE_DEC_DEF_50  = 10'h002;
  localparam logic [9:0]  LINE_DEC_DEF_60  = 10'h005;
  localparam logic [9:0]  LINE_XP_50       = 10'h017;
  localparam logic [9:0]  LINE_XP_60       = 10'h014;
  // Bus answers
  localparam logic [1:0]  RESP_OKAY        = 2'h0;
  localparam logic [1:0]  RESP_SLVERR      = 2'h2;
  typedef enum logic [3:0] {
    S_IDLE  = 4'b0001,
    S_SKIP  = 4'b0010,
    S_START = 4'b0100,
    S_RUN   = 4'b1000
  } task_state_t;
endpackage

// *** scaler_task_handler.sv ***
// Task handler and acquisition trigger of the video scaler, with AXI4-Lite registers.
// Assumes the acquisition counters outside report offset reach, position past offsets and task end.
// Operation
// - Decoder source: trigger on vertical pulse fall; edge select gives lines 4/7, 3/6.
// - All trigger selects zero: decoder start no earlier than line 2/5 both fields.
// - Stream source: start no earlier than SAV of line 23 or 20.
// - Two register sets; each task is selected only while its global enable bit is set.
// - Soft reset bit at zero returns task handler to initial state.
// - Enable changes act at task end; soft reset forces idle at once.
// - Start code: immediate, next vsync, next field id 0, next field id 1.
// - Field id for start is checked only when acquisition offsets are reached.
// - Repeat bit runs current task once more before handing over.
// - Skip the programmed number of fields before executing the task.
// - Task parity flag inverts at each activation of that task.
// - Activate on start condition and offsets; if already past, wait next vsync.
// - Trigger conditions checked only for the activated task, never while inactive.
// - After reset or soft reset task B has priority over task A.
// - Field id source zero: input field id on bit 6 and general pin.
// - Field id source one: task parity flag on bit 6 and general pin.
// - Marker zero keeps bit 7 high; marker one inverts bit 7.
// - Task output selected: general pins show the bit 7 task flag.
// - Parity flag is not synchronised to the input field detection.
// - Stream field id is line reference level at selected vertical edge.
// - Field id zero means first field of a frame.
`timescale 1ns/1ps
`default_nettype none
module scaler_task_handler
  import scaler_task_pkg::*;
(
  // Clock and reset
  input  wire logic                               aclk,
  input  wire logic                               aresetn,
  // AXI4-Lite slave
  input  wire logic [scaler_task_pkg::ADDR_W-1:0] awaddr,
  input  wire logic                               awvalid,
  output logic                                    awready,
  input  wire logic [31:0]                        wdata,
  input  wire logic [3:0]                         wstrb,
  input  wire logic                               wvalid,
  output logic                                    wready,
  output logic [1:0]                              bresp,
  output logic                                    bvalid,
  input  wire logic                               bready,
  input  wire logic [scaler_task_pkg::ADDR_W-1:0] araddr,
  input  wire logic                               arvalid,
  output logic                                    arready,
  output logic [31:0]                             rdata,
  output logic [1:0]                              rresp,
  output logic                                    rvalid,
  input  wire logic                               rready,
  // Internal decoder references
  input  wire logic                               decoder_vertical_pulse,
  input  wire logic                               decoder_line_reference,
  input  wire logic                               decoder_field_id,
  input  wire logic [9:0]                         decoder_line_count,
  // Expansion port stream
  input  wire logic                               xport_vert_ref,
  input  wire logic                               xport_horiz_ref,
  input  wire logic                               xport_sav,
  input  wire logic [9:0]                         xport_line_count,
  // Acquisition window
  input  wire logic                               offsets_reached,
  input  wire logic                               position_past_offsets,
  input  wire logic                               task_done,
  // Task outputs
  output logic                                    task_active,
  output logic                                    active_task_b,
  output logic                                    field_id_out,
  output logic                                    task_flag_out,
  output logic                                    general_purpose_out_0,
  output logic                                    general_purpose_out_1
);
  import scaler_task_pkg::*;

  typedef struct packed {
    logic                aw_held;
    logic [ADDR_W-1:0]   aw_addr;
    logic                w_held;
    logic [7:0]          w_data;
    logic                w_strb0;
    logic                bvalid;
    logic [1:0]          bresp;
    logic                rvalid;
    logic [31:0]         rdata;
    logic [1:0]          rresp;
    logic [7:0]          global_ctrl;
    logic [7:0]          gp_select;
    logic [7:0]          soft_reset;
    logic [7:0]          source_sel;
    logic [7:0]          trigger_sel;
    logic [7:0]          task_a_handling_control;
    logic [7:0]          task_b_handling_control;
    task_state_t         state;
    logic                cur_b;
    logic                repeat_used;
    logic [2:0]          skip_cnt;
    logic                wait_v;
    logic                earliest;
    logic                field_identifier;
    logic [1:0]          parity;
    logic                vpulse_d;
    logic                vref_d;
    logic                decoder_line_reference_d;
    logic                field_id_out;
    logic                task_flag_out;
    logic                gpo0;
    logic                gpo1;
  } handler_t;

  handler_t st;
  handler_t next_st;

  function automatic logic [7:0] task_ctrl(input handler_t s, input logic b);
    task_ctrl = b ? s.task_b_handling_control : s.task_a_handling_control;
  endfunction

  function automatic logic task_en(input handler_t s, input logic b);
    task_en = b ? s.global_ctrl[BIT_TASK_B_EN] : s.global_ctrl[BIT_TASK_A_EN];
  endfunction

  logic       srst;
  logic       src_x;
  logic       r60;
  logic       vsync_ev;
  logic       x_vedge;
  logic       decoder_line_reference_edge;
  logic       line_ev;
  logic [9:0] dec_line;
  logic [7:0] ctrl;
  logic [1:0] task_start_condition;
  logic       load_skip;
  logic [9:0] ridx;
  logic [9:0] widx;
  logic [7:0] load_ctrl;

  assign srst     = ~st.soft_reset[BIT_SOFT_RESET];
  assign src_x    = st.source_sel[BIT_SRC_XPORT];
  assign r60      = st.source_sel[BIT_RATE_60HZ];
  assign x_vedge  = st.trigger_sel[BIT_FD_EDGE] ? (xport_vert_ref & ~st.vref_d) : (~xport_vert_ref & st.vref_d);
  assign vsync_ev = src_x ? x_vedge : (st.vpulse_d & ~decoder_vertical_pulse);
  assign decoder_line_reference_edge = st.trigger_sel[BIT_HEDGE] ? (st.decoder_line_reference_d & ~decoder_line_reference)
                                               : (~st.decoder_line_reference_d & decoder_line_reference);
  always_comb begin
    if (st.trigger_sel[BIT_VEDGE]) begin
      if (~st.field_identifier) begin
        dec_line = r60 ? LINE_DEC_F1_60 : LINE_DEC_F1_50;
      end else begin
        dec_line = r60 ? LINE_DEC_F2_60 : LINE_DEC_F2_50;
      end
    end else begin
      dec_line = r60 ? LINE_DEC_DEF_60 : LINE_DEC_DEF_50;
    end
  end
  assign line_ev = src_x ? (xport_sav && xport_line_count >= (r60 ? LINE_XP_60 : LINE_XP_50))
                         : (decoder_line_reference_edge && decoder_line_count >= dec_line);
  assign ctrl = task_ctrl(st, st.cur_b);
  assign task_start_condition = ctrl[TASK_START_CONDITION_LSB +: 2];
  assign ridx = araddr[ADDR_W-1:2];
  assign widx = st.aw_addr[ADDR_W-1:2];

  always_comb begin
    next_st   = st;
    load_skip = 1'b0;
    load_ctrl = 8'h00;
    // Bus channels
    if (st.bvalid && bready) begin
      next_st.bvalid = 1'b0;
    end
    if (st.rvalid && rready) begin
      next_st.rvalid = 1'b0;
    end
    if (awvalid && awready) begin
      next_st.aw_held = 1'b1;
      next_st.aw_addr = awaddr;
    end
    if (wvalid && wready) begin
      next_st.w_held  = 1'b1;
      next_st.w_data  = wdata[7:0];
      next_st.w_strb0 = wstrb[0];
    end
    if (st.aw_held && st.w_held) begin
      next_st.aw_held = 1'b0;
      next_st.w_held  = 1'b0;
      next_st.bvalid  = 1'b1;
      next_st.bresp   = RESP_OKAY;
      unique case (widx)
        IDX_GLOBAL_CTRL: if (st.w_strb0) next_st.global_ctrl = st.w_data;
        IDX_GP_SELECT:   if (st.w_strb0) next_st.gp_select = st.w_data;
        IDX_SOFT_RESET:  if (st.w_strb0) next_st.soft_reset = st.w_data;
        IDX_TASK_A:      if (st.w_strb0) next_st.task_a_handling_control = st.w_data;
        IDX_SOURCE_SEL:  if (st.w_strb0) next_st.source_sel = st.w_data;
        IDX_TRIGGER_SEL: if (st.w_strb0) next_st.trigger_sel = st.w_data;
        IDX_TASK_B:      if (st.w_strb0) next_st.task_b_handling_control = st.w_data;
        IDX_STATUS:      next_st.bresp = RESP_OKAY;
        default:         next_st.bresp = RESP_SLVERR;
      endcase
    end
    if (arvalid && arready) begin
      next_st.rvalid = 1'b1;
      next_st.rresp  = RESP_OKAY;
      next_st.rdata  = 32'h0;
      unique case (ridx)
        IDX_GLOBAL_CTRL: next_st.rdata[7:0] = st.global_ctrl;
        IDX_GP_SELECT:   next_st.rdata[7:0] = st.gp_select;
        IDX_SOFT_RESET:  next_st.rdata[7:0] = st.soft_reset;
        IDX_TASK_A:      next_st.rdata[7:0] = st.task_a_handling_control;
        IDX_SOURCE_SEL:  next_st.rdata[7:0] = st.source_sel;
        IDX_TRIGGER_SEL: next_st.rdata[7:0] = st.trigger_sel;
        IDX_TASK_B:      next_st.rdata[7:0] = st.task_b_handling_control;
        IDX_STATUS:      next_st.rdata[7:0] = {st.state, st.cur_b, st.parity, st.field_identifier};
        default:         next_st.rresp = RESP_SLVERR;
      endcase
    end
    // Edge history and field detection
    next_st.vpulse_d = decoder_vertical_pulse;
    next_st.vref_d   = xport_vert_ref;
    next_st.decoder_line_reference_d   = decoder_line_reference;
    if (vsync_ev) begin
      next_st.field_identifier = (src_x ? xport_horiz_ref : decoder_field_id) ^ st.trigger_sel[BIT_FD_POL];
      next_st.earliest = 1'b0;
    end else if (line_ev) begin
      next_st.earliest = 1'b1;
    end
    // Task sequencing
    unique case (st.state)
      S_IDLE: begin
        if (task_en(st, 1'b0) || task_en(st, 1'b1)) begin
          next_st.cur_b       = task_en(st, st.cur_b) ? st.cur_b : ~st.cur_b;
          next_st.repeat_used = 1'b0;
          next_st.state       = S_SKIP;
          load_skip           = 1'b1;
        end
      end
      S_SKIP: begin
        if (st.skip_cnt == 3'h0) begin
          next_st.state  = S_START;
          next_st.wait_v = (task_start_condition == TASK_START_CONDITION_VSYNC);
        end else if (vsync_ev) begin
          next_st.skip_cnt = st.skip_cnt - 3'h1;
        end
      end
      S_START: begin
        if (st.wait_v) begin
          if (vsync_ev) begin
            next_st.wait_v = 1'b0;
          end
        end else if (st.earliest) begin
          if (position_past_offsets) begin
            next_st.wait_v = 1'b1;
          end else if (offsets_reached) begin
            if ((task_start_condition == TASK_START_CONDITION_FID0 && st.field_identifier) || (task_start_condition == TASK_START_CONDITION_FID1 && !st.field_identifier)) begin
              next_st.wait_v = 1'b1;
            end else begin
              next_st.state = S_RUN;
              next_st.parity[st.cur_b] = ~st.parity[st.cur_b];
            end
          end
        end
      end
      S_RUN: begin
        if (task_done) begin
          next_st.state = S_SKIP;
          load_skip     = 1'b1;
          if (ctrl[BIT_REPEAT] && !st.repeat_used && task_en(st, st.cur_b)) begin
            next_st.repeat_used = 1'b1;
          end else if (task_en(st, ~st.cur_b)) begin
            next_st.cur_b       = ~st.cur_b;
            next_st.repeat_used = 1'b0;
          end else if (task_en(st, st.cur_b)) begin
            next_st.repeat_used = 1'b0;
          end else begin
            next_st.state = S_IDLE;
            load_skip     = 1'b0;
          end
        end
      end
    endcase
    if (load_skip) begin
      load_ctrl        = task_ctrl(st, next_st.cur_b);
      next_st.skip_cnt = load_ctrl[SKIP_LSB +: 3];
      next_st.wait_v   = 1'b0;
    end
    if (srst) begin
      next_st.state       = S_IDLE;
      next_st.cur_b       = 1'b1;
      next_st.repeat_used = 1'b0;
      next_st.skip_cnt    = 3'h0;
      next_st.wait_v      = 1'b0;
      next_st.earliest    = 1'b0;
      next_st.parity      = 2'h0;
    end
    // Output codes
    next_st.field_id_out  = ctrl[BIT_OFID_SRC] ? st.parity[st.cur_b] : st.field_identifier;
    next_st.task_flag_out = ~ctrl[BIT_MARKER];
    next_st.gpo0 = st.gp_select[0] ? next_st.task_flag_out : next_st.field_id_out;
    next_st.gpo1 = st.gp_select[1] ? next_st.task_flag_out : next_st.field_id_out;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st            <= '0;
      st.soft_reset <= SOFT_RESET_INIT;
      st.state      <= S_IDLE;
      st.cur_b      <= 1'b1;
      st.task_flag_out <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign awready               = ~st.aw_held & ~st.bvalid;
  assign wready                = ~st.w_held & ~st.bvalid;
  assign bvalid                = st.bvalid;
  assign bresp                 = st.bresp;
  assign arready               = ~st.rvalid;
  assign rvalid                = st.rvalid;
  assign rdata                 = st.rdata;
  assign rresp                 = st.rresp;
  assign task_active           = (st.state == S_RUN);
  assign active_task_b         = st.cur_b;
  assign field_id_out          = st.field_id_out;
  assign task_flag_out         = st.task_flag_out;
  assign general_purpose_out_0 = st.gpo0;
  assign general_purpose_out_1 = st.gpo1;

  property p_soft_reset_idle;
    @(posedge aclk) disable iff (!aresetn) srst |=> (st.state == S_IDLE && st.cur_b && st.parity == 2'h0);
  endproperty
  a_soft_reset_idle: assert property (p_soft_reset_idle) else $error("soft reset did not idle");

  property p_run_holds;
    @(posedge aclk) disable iff (!aresetn) (st.state == S_RUN && !task_done && !srst) |=> st.state == S_RUN;
  endproperty
  a_run_holds: assert property (p_run_holds) else $error("task left before its end");

  property p_parity_flip;
    @(posedge aclk) disable iff (!aresetn)
      (st.state == S_RUN && $past(st.state) == S_START) |-> st.parity[st.cur_b] != $past(st.parity[st.cur_b]);
  endproperty
  a_parity_flip: assert property (p_parity_flip) else $error("parity did not invert");

  property p_fid_mismatch;
    @(posedge aclk) disable iff (!aresetn)
      (st.state == S_START && !st.wait_v && st.earliest && !position_past_offsets && offsets_reached
       && task_start_condition == TASK_START_CONDITION_FID0 && st.field_identifier && !srst) |=> (st.state == S_START && st.wait_v);
  endproperty
  a_fid_mismatch: assert property (p_fid_mismatch) else $error("started on wrong field id");

  property p_past_waits;
    @(posedge aclk) disable iff (!aresetn)
      (st.state == S_START && !st.wait_v && st.earliest && position_past_offsets && !srst) |=> st.wait_v;
  endproperty
  a_past_waits: assert property (p_past_waits) else $error("no wait for vsync when past offsets");

  property p_no_start_early;
    @(posedge aclk) disable iff (!aresetn) (st.state == S_START && !st.earliest) |=> st.state != S_RUN;
  endproperty
  a_no_start_early: assert property (p_no_start_early) else $error("started before earliest line");

  property p_skip_holds;
    @(posedge aclk) disable iff (!aresetn)
      (st.state == S_SKIP && st.skip_cnt != 3'h0 && !vsync_ev && !srst) |=> (st.state == S_SKIP && $stable(st.skip_cnt));
  endproperty
  a_skip_holds: assert property (p_skip_holds) else $error("skip count moved without a field");

  property p_repeat_same;
    @(posedge aclk) disable iff (!aresetn)
      (st.state == S_RUN && task_done && ctrl[BIT_REPEAT] && !st.repeat_used && task_en(st, st.cur_b) && !srst)
      |=> (st.cur_b == $past(st.cur_b) && st.repeat_used);
  endproperty
  a_repeat_same: assert property (p_repeat_same) else $error("repeat did not rerun task");

  property p_marker_bit;
    @(posedge aclk) disable iff (!aresetn) ##1 (task_flag_out == ~$past(ctrl[BIT_MARKER]));
  endproperty
  a_marker_bit: assert property (p_marker_bit) else $error("bit 7 flag wrong");

  property p_fid_source;
    @(posedge aclk) disable iff (!aresetn)
      (!ctrl[BIT_OFID_SRC]) |=> field_id_out == $past(st.field_identifier);
  endproperty
  a_fid_source: assert property (p_fid_source) else $error("bit 6 not input field id");
endmodule
`default_nettype wire

// *** video_source_model.sv ***
// Free-running decoder and stream reference model for the scaler task handler.
// Assumes one clock; fields of 12 lines, 4 cycles a line.
`timescale 1ns/1ps
`default_nettype none
module video_source_model (
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Decoder references
  output logic       decoder_vertical_pulse,
  output logic       decoder_line_reference,
  output logic       decoder_field_id,
  output logic [9:0] decoder_line_count,
  // Expansion port stream and acquisition window
  output logic       xport_vert_ref,
  output logic       xport_horiz_ref,
  output logic       xport_sav,
  output logic [9:0] xport_line_count,
  output logic       offsets_reached,
  output logic       position_past_offsets,
  output logic       task_done
);
  logic [3:0] line;
  logic [1:0] pix;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      line <= 4'h0;
      pix <= 2'h0;
      decoder_field_id <= 1'b1;
    end else begin
      pix <= pix + 2'h1;
      if (pix == 2'h3) begin
        line <= (line == 4'hb) ? 4'h0 : line + 4'h1;
        if (line == 4'hb) decoder_field_id <= ~decoder_field_id;  // Alternating fields
      end
    end
  end
  assign decoder_vertical_pulse = (line == 4'h0);  // Falls at line 1
  assign decoder_line_reference = (pix < 2'h2);
  assign decoder_line_count     = {6'h00, line};
  assign xport_vert_ref         = (line == 4'h0);  // Falls at line 1
  assign xport_horiz_ref        = ~decoder_field_id;  // Field id level opposite to decoder
  assign xport_sav              = (pix == 2'h0);
  assign xport_line_count       = {6'h00, line} + 10'h010;  // Stream lines 16 to 27
  assign offsets_reached        = (line == 4'h6);
  assign position_past_offsets  = (line > 4'h6);
  assign task_done              = (line == 4'h9) && (pix == 2'h0);
endmodule
`default_nettype wire

// *** testbench.sv ***
// Self-checking bench for the scaler task handler over AXI4-Lite.
// Assumes the free-running decoder model drives the video side.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin bad_count++; \
  $display("Error %0t: got %h want %h", $time, a, b); end end
module testbench;
  import scaler_task_pkg::*;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, r;
  logic        vp, lr, field_identifier, ofs, past, done;
  logic        xvr, xhr, xsav;
  logic        act, is_b, fid_o, flag_o, gp0, gp1;
  logic [9:0]  lc, xlc;
  int          bad_count, total_checks, c;
  initial begin
    aclk = 0;
    forever #2 aclk = ~aclk;
  end
  video_source_model u_video_source_model (.aclk(aclk), .aresetn(aresetn), .decoder_vertical_pulse(vp),
    .decoder_line_reference(lr), .decoder_field_id(field_identifier), .decoder_line_count(lc), .offsets_reached(ofs),
    .position_past_offsets(past), .task_done(done), .xport_vert_ref(xvr), .xport_horiz_ref(xhr),
    .xport_sav(xsav), .xport_line_count(xlc));
  scaler_task_handler u_scaler_task_handler (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .decoder_vertical_pulse(vp),
    .decoder_line_reference(lr), .decoder_field_id(field_identifier), .decoder_line_count(lc), .xport_vert_ref(xvr),
    .xport_horiz_ref(xhr), .xport_sav(xsav), .xport_line_count(xlc), .offsets_reached(ofs),
    .position_past_offsets(past), .task_done(done), .task_active(act), .active_task_b(is_b),
    .field_id_out(fid_o), .task_flag_out(flag_o), .general_purpose_out_0(gp0), .general_purpose_out_1(gp1));
  task automatic report_and_stop();
    if (bad_count == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic edge_until(ref logic s);
    for (int n = 0; n < 2000; n++) begin
      @(posedge aclk);
      if (s === 1'b1) return;
    end
    bad_count++;
    report_and_stop();
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    edge_until(awready);
    awvalid <= 1'b0;
    if (wready !== 1'b1) edge_until(wready);
    wvalid <= 1'b0;
    edge_until(bvalid);
    bready <= 1'b0;
    `CHK(bresp, RESP_OKAY)
  endtask
  task automatic rd(input logic [11:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    edge_until(arready);
    arvalid <= 1'b0;
    edge_until(rvalid);
    rready <= 1'b0;
    d = rdata;
    r = rresp;
  endtask
  task automatic next_act();
    if (act === 1'b1) edge_until(done);
    edge_until(act);
    repeat (2) @(posedge aclk);
  endtask
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, araddr, wdata, wstrb} = '0;
    bad_count = 0;
    total_checks = 0;
    wstrb = 4'hf;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(12'h218);
    `CHK(d & 32'hfe, 32'h18)
    rd(12'h220);
    `CHK(d, 32'h20)
    rd(12'h3fc);
    `CHK(r, RESP_SLVERR)
    wr(12'h21c, 32'h1);
    wr(12'h240, 32'hc0);
    wr(12'h200, 32'h10);
    next_act();
    `CHK({is_b, flag_o, fid_o}, 3'b001)
    `CHK({gp0, gp1}, 2'b01)
    next_act();
    `CHK(fid_o, 1'b0)
    wr(12'h220, 32'h0);
    @(posedge aclk);
    `CHK(act, 1'b0)
    rd(12'h218);
    `CHK(d & 32'hfe, 32'h18)
    wr(12'h300, 32'h04);
    wr(12'h240, 32'h00);
    wr(12'h200, 32'h30);
    wr(12'h220, 32'h20);
    next_act();
    `CHK({is_b, flag_o, fid_o}, {2'b11, field_identifier})
    next_act();
    `CHK(is_b, 1'b1)
    next_act();
    `CHK(is_b, 1'b0)
    wr(12'h200, 32'h10);
    for (c = 2; c < 4; c++) begin
      wr(12'h220, 32'h0);
      wr(12'h240, c);
      wr(12'h220, 32'h20);
      next_act();
      `CHK(fid_o, c[0])
    end
    wr(12'h220, 32'h0);
    wr(12'h244, 32'h50);
    wr(12'h240, 32'h1);
    wr(12'h220, 32'h20);
    next_act();
    `CHK(fid_o, ~field_identifier)
    `CHK(is_b, 1'b0)
    report_and_stop();
  end
endmodule
`default_nettype wire
